//--- rtl/fsps_regs.svh
// Register offsets, field positions, reset values and timing counts of the flash sequencer
// Notes on behaviour
// - Row is 32 words; erase clears one row
// - Panel holds 128 rows of 24-bit words
// - Software reloads table pointer crossing panel boundary
// - Panel latches hold 32 words; program writes all
// - Latches filled ascending from row-aligned word zero
// - Pointer setup, table writes, then start bits
// - Row load is 32 low, 32 high writes
// - Each latch table write takes two cycles
// - One start programs at most one row
// - Control selects erase, memory type, start bit
// - Low address captures table address bits 15..0
// - Upper address captures table address bits 23..16
// - Key write-only; 0x55 then 0xAA unlocks start
// - Both address registers accept direct writes
// - Flash usable during normal run, no mode
`ifndef FSPS_REGS_SVH
`define FSPS_REGS_SVH
`define FSPS_ADDR_CTRL      4'h0
`define FSPS_ADDR_ADRLOW    4'h2
`define FSPS_ADDR_ADRUP     4'h4
`define FSPS_ADDR_KEY       4'h6
`define FSPS_CTRL_START     15
`define FSPS_CTRL_ERR       13
`define FSPS_CTRL_ERASE     6
`define FSPS_CTRL_TYPE      0
`define FSPS_CTRL_RST       16'h0000
`define FSPS_KEY_FIRST      8'h55
`define FSPS_KEY_SECOND     8'hAA
`define FSPS_ROW_WORDS      32
`define FSPS_PANEL_ROWS     128
`define FSPS_TBLWR_CYCLES   2
`define FSPS_OP_TIME_US     2
`define FSPS_CLK_MHZ        200
`endif

//--- rtl/fsps_pkg.sv
// Sequencer state type and the request kind shared by both ends of the flash sequencer
package fsps_pkg;
   typedef enum logic [1:0] {
      FSPS_IDLE  = 2'b00,
      FSPS_LATCH = 2'b01,
      FSPS_BUSY  = 2'b10
   } fsps_state_e;
   typedef enum logic [1:0] {
      FSPS_REQ_NONE  = 2'b00,
      FSPS_REQ_TBLWL = 2'b01,
      FSPS_REQ_TBLWH = 2'b10,
      FSPS_REQ_REG   = 2'b11
   } fsps_req_e;
endpackage

//--- rtl/fsps_link_if.sv
// Interface joining the processor core end to the flash sequencer end
`timescale 1ns/100ps
`default_nettype none
interface fsps_link_if;
   logic                 reqValid;
   fsps_pkg::fsps_req_e  reqKind;
   logic [23:0]          reqAddr;
   logic [15:0]          reqData;
   logic                 reqReady;
   logic [15:0]          rdData;
   logic                 busy;
   modport device (input reqValid, reqKind, reqAddr, reqData,
                   output reqReady, rdData, busy);
   modport core   (output reqValid, reqKind, reqAddr, reqData,
                   input reqReady, rdData, busy);
endinterface
`default_nettype wire

//--- rtl/fsps_sequencer.sv
// Flash self-programming sequencer: latches, address capture, key unlock, row operations
`timescale 1ns/100ps
`default_nettype none
`include "fsps_regs.svh"
module fsps_sequencer #(
   parameter int ROW_WORDS  = `FSPS_ROW_WORDS,
   parameter int PANEL_ROWS = `FSPS_PANEL_ROWS,
   parameter int NUM_PANELS = 1,
   parameter int OP_CYCLES  = `FSPS_OP_TIME_US * `FSPS_CLK_MHZ
) (
   input  wire logic  ref_clk,
   input  wire logic  rst_n,
   fsps_link_if.device link,
   output logic       opDone,
   output logic       flashRdValid,
   output logic [23:0] flashRdWord
);
   localparam int WORDS = ROW_WORDS * PANEL_ROWS * NUM_PANELS;
   localparam int AW    = $clog2(WORDS);
   localparam int LW    = $clog2(ROW_WORDS);

   typedef struct packed {
      fsps_pkg::fsps_state_e state;
      logic [15:0]           ctrl;
      logic [15:0]           adrLow;
      logic [7:0]            adrUp;
      logic                  keyHalf;
      logic                  unlocked;
      logic [15:0]           cnt;
      logic                  ready;
      logic                  busy;
      logic                  done;
      logic                  rdValid;
      logic [23:0]           rdWord;
      logic [15:0]           rdData;
      logic [15:0]           lo;
      logic [7:0]            hi;
      logic [LW-1:0]         latIdx;
      logic                  latWr;
   } fsps_seq_s;

   fsps_seq_s cur_ff;
   fsps_seq_s nxt_cur;
   logic [23:0] flashMem [WORDS];
   logic [23:0] latch    [ROW_WORDS];

   // Word address from captured byte address; program counter steps by two
   function automatic logic [AW-1:0] wordOf(input logic [23:0] ea);
      wordOf = ea[AW:1];
   endfunction

   wire logic [AW-1:0] rowBase = wordOf({cur_ff.adrUp, cur_ff.adrLow}) & ~AW'(ROW_WORDS - 1);

   // Next-state logic
   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.ready   = 1'b0;
      nxt_cur.done    = 1'b0;
      nxt_cur.rdValid = 1'b0;
      nxt_cur.latWr   = 1'b0;
      case (cur_ff.state)
         fsps_pkg::FSPS_IDLE: begin
            if (link.reqValid && !cur_ff.ready) begin
               // Every table instruction records its address
               if (link.reqKind != fsps_pkg::FSPS_REQ_REG) begin
                  nxt_cur.adrLow = link.reqAddr[15:0];
                  nxt_cur.adrUp  = link.reqAddr[23:16];
                  nxt_cur.latIdx = link.reqAddr[LW:1];
                  nxt_cur.keyHalf = 1'b0;
                  nxt_cur.unlocked = 1'b0;
                  if (link.reqKind == fsps_pkg::FSPS_REQ_TBLWH) begin
                     nxt_cur.hi = link.reqData[7:0];
                  end else begin
                     nxt_cur.lo = link.reqData;
                  end
                  nxt_cur.latWr = 1'b1;
                  nxt_cur.state = fsps_pkg::FSPS_LATCH;
               end else begin
                  nxt_cur.ready = 1'b1;
                  nxt_cur.keyHalf  = 1'b0;
                  nxt_cur.unlocked = 1'b0;
                  case (link.reqAddr[3:0])
                     `FSPS_ADDR_CTRL: begin
                        nxt_cur.ctrl = link.reqData & ~(16'h1 << `FSPS_CTRL_START);
                        if (link.reqData[`FSPS_CTRL_START]) begin
                           if (cur_ff.unlocked) begin
                              nxt_cur.ctrl[`FSPS_CTRL_START] = 1'b1;
                              nxt_cur.ctrl[`FSPS_CTRL_ERR]   = 1'b0;
                              nxt_cur.busy  = 1'b1;
                              nxt_cur.cnt   = 16'(OP_CYCLES);
                              nxt_cur.state = fsps_pkg::FSPS_BUSY;
                           end else begin
                              nxt_cur.ctrl[`FSPS_CTRL_ERR] = 1'b1;
                           end
                        end
                     end
                     `FSPS_ADDR_ADRLOW: nxt_cur.adrLow = link.reqData;
                     `FSPS_ADDR_ADRUP:  nxt_cur.adrUp  = link.reqData[7:0];
                     `FSPS_ADDR_KEY: begin
                        if (link.reqData[7:0] == `FSPS_KEY_FIRST) begin
                           nxt_cur.keyHalf = 1'b1;
                        end else if (cur_ff.keyHalf && link.reqData[7:0] == `FSPS_KEY_SECOND) begin
                           nxt_cur.unlocked = 1'b1;
                        end
                     end
                     default: ;
                  endcase
                  // Reads; key reads as zero since it is write-only
                  case (link.reqAddr[3:0])
                     `FSPS_ADDR_CTRL:   nxt_cur.rdData = cur_ff.ctrl;
                     `FSPS_ADDR_ADRLOW: nxt_cur.rdData = cur_ff.adrLow;
                     `FSPS_ADDR_ADRUP:  nxt_cur.rdData = {8'h00, cur_ff.adrUp};
                     default:           nxt_cur.rdData = 16'h0000;
                  endcase
               end
            end
         end
         fsps_pkg::FSPS_LATCH: begin
            nxt_cur.ready = 1'b1;
            nxt_cur.state = fsps_pkg::FSPS_IDLE;
         end
         fsps_pkg::FSPS_BUSY: begin
            if (cur_ff.cnt == 16'h0001) begin
               nxt_cur.ctrl[`FSPS_CTRL_START] = 1'b0;
               nxt_cur.busy  = 1'b0;
               nxt_cur.done  = 1'b1;
               nxt_cur.state = fsps_pkg::FSPS_IDLE;
            end
            nxt_cur.cnt = cur_ff.cnt - 16'h0001;
         end
         default: nxt_cur.state = fsps_pkg::FSPS_IDLE;
      endcase
      // Flash reads through the upper and low address while idle with no request pending, no special mode needed
      if (cur_ff.state == fsps_pkg::FSPS_IDLE && !link.reqValid) begin
         nxt_cur.rdWord  = flashMem[wordOf({cur_ff.adrUp, cur_ff.adrLow})];
         nxt_cur.rdValid = 1'b1;
      end
   end

   // State register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cur_ff <= '0;
         cur_ff.ctrl <= `FSPS_CTRL_RST;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // Latch and array storage; one row per operation
   always_ff @(posedge ref_clk) begin
      if (cur_ff.latWr && cur_ff.state == fsps_pkg::FSPS_LATCH) begin
         if (link.reqKind == fsps_pkg::FSPS_REQ_TBLWH) begin
            latch[cur_ff.latIdx][23:16] <= cur_ff.hi;
         end else begin
            latch[cur_ff.latIdx][15:0] <= cur_ff.lo;
         end
      end
      if (cur_ff.state == fsps_pkg::FSPS_BUSY && cur_ff.cnt == 16'h0001) begin
         for (int i = 0; i < ROW_WORDS; i++) begin
            if (cur_ff.ctrl[`FSPS_CTRL_ERASE]) begin
               flashMem[rowBase + AW'(i)] <= 24'hFFFFFF;
            end else if (cur_ff.ctrl[`FSPS_CTRL_TYPE]) begin
               flashMem[rowBase + AW'(i)] <= latch[i];
            end
         end
      end
   end

   assign link.reqReady = cur_ff.ready;
   assign link.rdData   = cur_ff.rdData;
   assign link.busy     = cur_ff.busy;
   assign opDone        = cur_ff.done;
   assign flashRdValid  = cur_ff.rdValid;
   assign flashRdWord   = cur_ff.rdWord;
endmodule
`default_nettype wire

//--- rtl/fsps_core_end.sv
// Core-side end: turns user commands into table writes and register accesses
`timescale 1ns/100ps
`default_nettype none
`include "fsps_regs.svh"
module fsps_core_end (
   input  wire logic                 ref_clk,
   input  wire logic                 rst_n,
   fsps_link_if.core                 link,
   input  wire logic                 cmdValid,
   input  wire fsps_pkg::fsps_req_e  cmdKind,
   input  wire logic [23:0]          cmdAddr,
   input  wire logic [15:0]          cmdData,
   output logic                      cmdAck,
   output logic [15:0]               cmdRdData,
   output logic                      flashBusy
);
   typedef struct packed {
      logic                reqValid;
      fsps_pkg::fsps_req_e reqKind;
      logic [23:0]         reqAddr;
      logic [15:0]         reqData;
      logic                ack;
      logic [15:0]         rd;
      logic                busy;
   } fsps_core_s;

   fsps_core_s cur_ff;
   fsps_core_s nxt_cur;

   // One request outstanding; held until the sequencer answers
   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.ack  = 1'b0;
      nxt_cur.busy = link.busy;
      if (cur_ff.reqValid) begin
         if (link.reqReady) begin
            nxt_cur.reqValid = 1'b0;
            nxt_cur.ack      = 1'b1;
            nxt_cur.rd       = link.rdData;
         end
      end else if (cmdValid && !cur_ff.ack) begin
         nxt_cur.reqValid = 1'b1;
         nxt_cur.reqKind  = cmdKind;
         nxt_cur.reqAddr  = cmdAddr;
         nxt_cur.reqData  = cmdData;
      end
   end

   // State register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   assign link.reqValid = cur_ff.reqValid;
   assign link.reqKind  = cur_ff.reqKind;
   assign link.reqAddr  = cur_ff.reqAddr;
   assign link.reqData  = cur_ff.reqData;
   assign cmdAck        = cur_ff.ack;
   assign cmdRdData     = cur_ff.rd;
   assign flashBusy     = cur_ff.busy;
endmodule
`default_nettype wire

//--- testbench/fsps_link_props.sv
// Concurrent checks on the link between core end and sequencer
`timescale 1ns/100ps
`default_nettype none
`include "fsps_regs.svh"
module fsps_link_props #(
   parameter int OP_CYCLES = 4
) (
   input wire logic                ref_clk,
   input wire logic                rst_n,
   input wire logic                reqValid,
   input wire fsps_pkg::fsps_req_e reqKind,
   input wire logic [23:0]         reqAddr,
   input wire logic [15:0]         reqData,
   input wire logic                reqReady,
   input wire logic [15:0]         rdData,
   input wire logic                busy
);
   localparam logic [13:0] KEY1 = {2'h3, `FSPS_ADDR_KEY, `FSPS_KEY_FIRST};
   localparam logic [13:0] KEY2 = {2'h3, `FSPS_ADDR_KEY, `FSPS_KEY_SECOND};
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic [13:0] lastReq_ff;
   logic [13:0] prevReq_ff;
   logic [15:0] busyCnt_ff;
   wire logic   isReg = (reqKind == fsps_pkg::FSPS_REQ_REG);
   wire logic   isCtrl = isReg && (reqAddr[3:0] == `FSPS_ADDR_CTRL);
   // History of completed requests and length of the busy phase
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         lastReq_ff <= 14'h0000;
         prevReq_ff <= 14'h0000;
         busyCnt_ff <= 16'h0000;
      end else begin
         if (reqReady) begin
            lastReq_ff <= {reqKind, reqAddr[3:0], reqData[7:0]};
            prevReq_ff <= lastReq_ff;
         end
         busyCnt_ff <= busy ? busyCnt_ff + 16'h0001 : 16'h0000;
      end
   end
   reg_answer_a: assert property ($rose(reqValid) && isReg && !busy |=> reqReady)
      else $error("register request not answered next cycle");
   tbl_answer_a: assert property ($rose(reqValid) && !isReg && !busy |=> !reqReady ##1 reqReady)
      else $error("table write not answered in two cycles");
   ready_pulse_a: assert property (reqReady |=> !reqReady)
      else $error("ready held longer than one cycle");
   busy_refuse_a: assert property (busy && !$rose(busy) |-> !reqReady)
      else $error("request answered during row operation");
   unlock_start_a: assert property ($rose(busy) |-> reqReady && isCtrl
      && reqData[`FSPS_CTRL_START] && lastReq_ff == KEY2 && prevReq_ff == KEY1)
      else $error("operation started without unlock");
   start_busy_a: assert property (reqReady && isCtrl && reqData[`FSPS_CTRL_START]
      && lastReq_ff == KEY2 && prevReq_ff == KEY1 |-> busy)
      else $error("unlocked start did not begin");
   op_length_a: assert property ($fell(busy) |-> busyCnt_ff == OP_CYCLES)
      else $error("row operation length wrong");
   key_read_a: assert property (reqReady && isReg && reqAddr[3:0] == `FSPS_ADDR_KEY
      |-> rdData == 16'h0000)
      else $error("key register readable");
endmodule
`default_nettype wire

//--- testbench/flash_self_program_sequencer_test.sv
// Self-checking bench joining the core end and the sequencer through the link
`timescale 1ns/100ps
`default_nettype none
`include "fsps_regs.svh"
module flash_self_program_sequencer_test;
   localparam int OP_CYC = 20;
   logic                ref_clk;
   logic                rst_n;
   logic                cmdValid;
   fsps_pkg::fsps_req_e cmdKind;
   logic [23:0]         cmdAddr;
   logic [15:0]         cmdData;
   logic                cmdAck;
   logic [15:0]         cmdRdData;
   logic                flashBusy;
   logic                opDone;
   logic                flashRdValid;
   logic [23:0]         flashRdWord;
   int                  nErrors = 0;
   int                  checks = 0;
   int                  cycles = 0;
   // Rows: address low beside the word expected there after programming
   logic [39:0]         rowTab [4] = '{40'h010030A500, 40'h010231A501,
                                       40'h013C4EA51E, 40'h013E4FA51F};
   fsps_link_if linkIf ();
   fsps_sequencer #(.OP_CYCLES(OP_CYC)) fsps_sequencer_inst (.ref_clk(ref_clk), .rst_n(rst_n),
      .link(linkIf.device), .opDone(opDone), .flashRdValid(flashRdValid),
      .flashRdWord(flashRdWord));
   fsps_core_end fsps_core_end_inst (.ref_clk(ref_clk), .rst_n(rst_n), .link(linkIf.core),
      .cmdValid(cmdValid), .cmdKind(cmdKind), .cmdAddr(cmdAddr), .cmdData(cmdData),
      .cmdAck(cmdAck), .cmdRdData(cmdRdData), .flashBusy(flashBusy));
   fsps_link_props #(.OP_CYCLES(OP_CYC)) fsps_link_props_inst (.ref_clk(ref_clk),
      .rst_n(rst_n), .reqValid(linkIf.reqValid), .reqKind(linkIf.reqKind),
      .reqAddr(linkIf.reqAddr), .reqData(linkIf.reqData), .reqReady(linkIf.reqReady),
      .rdData(linkIf.rdData), .busy(linkIf.busy));
   // Clock and hang guard
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         nErrors++;
         complete_run();
      end
   end
   task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
      checks++;
      if (seen !== exp) begin
         nErrors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic cmd(input fsps_pkg::fsps_req_e k, input logic [23:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      cmdValid <= 1'b1;
      cmdKind <= k;
      cmdAddr <= a;
      cmdData <= d;
      do begin
         @(posedge ref_clk);
         n++;
      end while (cmdAck !== 1'b1 && n < 40);
      cmdValid <= 1'b0;
      check("cmdAck", 24'(cmdAck), 24'h000001);
   endtask
   task automatic regWr(input logic [3:0] a, input logic [15:0] d);
      cmd(fsps_pkg::FSPS_REQ_REG, {20'h00000, a}, d);
   endtask
   task automatic startOp(input logic [15:0] k1, k2, ctl, input logic gap);
      regWr(`FSPS_ADDR_KEY, k1);
      check("keyRead", 24'(cmdRdData), 24'h000000);
      // Upper address still holds the byte captured by the table writes
      if (gap) begin
         regWr(`FSPS_ADDR_ADRUP, 16'h0000);
         check("adrUpOld", 24'(cmdRdData), 24'h000005);
      end
      regWr(`FSPS_ADDR_KEY, k2);
      regWr(`FSPS_ADDR_CTRL, ctl);
   endtask
   task automatic waitEdge(input logic which);
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while ((which ? opDone : flashRdValid) !== 1'b1 && n < 60);
   endtask
   task automatic readRows(input logic erased);
      for (int i = 0; i < 4; i++) begin
         regWr(`FSPS_ADDR_ADRLOW, rowTab[i][39:24]);
         // The write answers with the previous low address
         check("adrLowOld", 24'(cmdRdData), 24'(rowTab[(i + 3) % 4][39:24]));
         waitEdge(1'b0);
         check("flashRdValid", 24'(flashRdValid), 24'h000001);
         check("flashRdWord", flashRdWord, erased ? 24'hFFFFFF : rowTab[i][23:0]);
      end
   endtask
   task automatic quiet();
      int hits;
      hits = 0;
      repeat (12) begin
         @(posedge ref_clk);
         hits += int'(opDone === 1'b1 || flashBusy === 1'b1);
      end
      check("refusedStart", 24'(hits), 24'h000000);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, nErrors);
      if (nErrors == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      rst_n = 1'b0;
      cmdValid = 1'b0;
      cmdKind = fsps_pkg::FSPS_REQ_NONE;
      cmdAddr = 24'h000000;
      cmdData = 16'h0000;
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      check("idleOutputs", {21'h000000, cmdAck, flashBusy, opDone}, 24'h000000);
      $display("test reset finished");
      for (int i = 0; i < 32; i++) begin
         cmd(fsps_pkg::FSPS_REQ_TBLWL, 24'h050100 + 24'(2 * i), 16'hA500 + 16'(i));
         cmd(fsps_pkg::FSPS_REQ_TBLWH, 24'h050100 + 24'(2 * i), 16'h0030 + 16'(i));
      end
      startOp(16'h0055, 16'h00AA, 16'h8001, 1'b0);
      waitEdge(1'b1);
      check("opDone", 24'(opDone), 24'h000001);
      readRows(1'b0);
      $display("test program finished");
      startOp(16'h0055, 16'h00AA, 16'h8040, 1'b0);
      waitEdge(1'b1);
      check("opDone", 24'(opDone), 24'h000001);
      readRows(1'b1);
      $display("test erase finished");
      startOp(16'h00AA, 16'h0055, 16'h8001, 1'b0);
      quiet();
      // Refused start leaves the error bit standing in the control register
      regWr(`FSPS_ADDR_CTRL, 16'h0000);
      check("ctrlError", 24'(cmdRdData), 24'h002001);
      startOp(16'h0055, 16'h00AA, 16'h8001, 1'b1);
      quiet();
      readRows(1'b1);
      $display("test refused finished");
      startOp(16'h0055, 16'h00AA, 16'h8040, 1'b0);
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      check("busyAfterReset", 24'(flashBusy), 24'h000000);
      $display("test midReset finished");
      complete_run();
   end
endmodule
`default_nettype wire
